// [verilog/wake_source_control_regs.sv]
// Wake source control register bank with its serial register port.
// Assumes mode, soft reset and watchdog bit updates come from logic on the same clock;
// serial pins are asynchronous to it and are synchronised here.
//
// Overview of operation
// - Reserved bits always read back as zero, whatever is written.
// - Peak register bit 5 picks low (0) or high (1) supply peak threshold.
// - Peak threshold bit is writable only in Init or Normal mode.
// - Ignored peak write in Stop raises no write fault and no interrupt.
// - Peak register clears on reset; restart clears all but bit 5.
// - Fail-safe entry loads bus and external wake registers with wake patterns.
// - Internal wake bits 7 and 6 enable timer 2 and timer 1 wakes.
// - Internal wake bit 2 disables Stop watchdog; device may update it.
// - External bit 7 chooses wake-only or all-status interrupt scope.
// - External bit 5 selects measurement and masks wake inputs 1 and 2.
// - With measurement, it runs in Normal and pin 1/2 levels are meaningless.
// - External bits 2, 1, 0 enable wake inputs 3, 2, 1.
// - External register resets to 07h; restart clears bits 6, 4 and 3.
// - Pull field codes: none, pull-down, pull-up, automatic.
// - Pull fields sit at 5:4, 3:2 and 1:0 for inputs 3, 2, 1.
// - Watchdog control bit 6 is the companion Stop watchdog disable bit.
// - Transceiver codes 001 and 101 make the bus wake capable.
`include "wake_source_map.svh"
`timescale 1ns/1ps
`default_nettype none

module wake_source_control_regs (
  input  wire logic                       clock,
  input  wire logic                       sys_rst,
  input  wire logic                       clk_en,
  input  wire logic                       soft_rst,
  input  wire wake_source_pkg::chip_mode_t chip_mode,
  input  wire logic                       stop_watchdog_off_lo,
  input  wire logic                       wd_off_hi_hw_set,
  input  wire logic                       wd_off_hi_hw_clr,
  input  wire logic [2:0]                 can_mode_field,
  input  wire logic                       spi_csn_n,
  input  wire logic                       spi_clk,
  input  wire logic                       spi_sdi,
  output logic                            spi_sdo,
  output logic                            spi_sdo_en,
  output logic                            write_fault,
  output logic                            supply_peak_threshold_select,
  output logic                            second_timer_wake_enable,
  output logic                            first_timer_wake_enable,
  output logic                            stop_watchdog_off_hi,
  output logic                            stop_watchdog_disable,
  output logic                            int_all_status,
  output logic                            wake_pin_measure_select,
  output logic                            measure_active,
  output logic                            level_status_valid,
  output logic                            wake_input_one_enable,
  output logic                            wake_input_two_enable,
  output logic                            wake_input_three_enable,
  output logic [1:0]                      wake_input_one_pull,
  output logic [1:0]                      wake_input_two_pull,
  output logic [1:0]                      wake_input_three_pull,
  output logic [2:0]                      pull_up_enable,
  output logic [2:0]                      pull_down_enable,
  output logic [2:0]                      pull_auto_enable,
  output logic                            can_wake_capable,
  output logic                            bus_failsafe_load,
  output logic [7:0]                      bus_failsafe_keep,
  output logic [7:0]                      bus_failsafe_value
);

  // Register contents
  logic [7:0]                 peak_r;
  logic [7:0]                 internal_r;
  logic [7:0]                 external_r;
  logic [7:0]                 bias_r;
  wake_source_pkg::chip_mode_t mode_prev_r;
  logic                       por;
  logic                       enter_restart;
  logic                       enter_failsafe;

  // Serial pin synchronisers; stage one is read only by stage two
  logic [1:0]                 csn_sync_r;
  logic [1:0]                 clk_sync_r;
  logic [1:0]                 sdi_sync_r;
  logic                       csn_last_r;
  logic                       clk_last_r;
  logic                       sclk_rise;
  logic                       sclk_fall;
  logic                       frame_start;
  logic                       frame_end;

  // Serial frame engine
  logic [4:0]                 bit_cnt_r;
  logic [15:0]                rx_r;
  logic [7:0]                 tx_r;
  logic [7:0]                 read_data;
  logic                       wr_commit;
  logic [6:0]                 wr_addr;
  logic [7:0]                 wr_data;
  logic                       wr_peak_ok;

  assign por            = sys_rst | soft_rst;

  assign enter_restart  = (chip_mode == wake_source_pkg::MODE_RESTART) &&
                          (mode_prev_r != wake_source_pkg::MODE_RESTART);

  assign enter_failsafe = (chip_mode == wake_source_pkg::MODE_FAIL_SAFE) &&
                          (mode_prev_r != wake_source_pkg::MODE_FAIL_SAFE);

  assign sclk_rise      = clk_sync_r[1] & ~clk_last_r;
  assign sclk_fall      = ~clk_sync_r[1] & clk_last_r;
  assign frame_start    = ~csn_sync_r[1] & csn_last_r;
  assign frame_end      = csn_sync_r[1] & ~csn_last_r;

  // Frame is address[6:0] then write flag then data[7:0], each LSB first
  assign wr_addr        = rx_r[6:0];
  assign wr_data        = rx_r[15:8];

  // Short or long frames never write: half a byte must not land in a register
  assign wr_commit      = frame_end && (bit_cnt_r == `FRAME_BITS) && rx_r[7];
  assign wr_peak_ok     = (chip_mode == wake_source_pkg::MODE_INIT) ||
                          (chip_mode == wake_source_pkg::MODE_NORMAL);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      csn_sync_r <= 2'h3;
      clk_sync_r <= 2'h0;
      sdi_sync_r <= 2'h0;
      csn_last_r <= 1'b1;
      clk_last_r <= 1'b0;
    end else if (clk_en) begin
      csn_sync_r <= {csn_sync_r[0], spi_csn_n};
      clk_sync_r <= {clk_sync_r[0], spi_clk};
      sdi_sync_r <= {sdi_sync_r[0], spi_sdi};
      csn_last_r <= csn_sync_r[1];
      clk_last_r <= clk_sync_r[1];
    end
  end

  // Register contents by frame address, used by the write fault check
  always_comb begin
    case (wr_addr)
      `PEAK_THRESHOLD_CTRL_ADDR: read_data = peak_r;
      `INTERNAL_WAKE_CTRL_ADDR:  read_data = internal_r;
      `EXTERNAL_WAKE_CTRL_ADDR:  read_data = external_r;
      `WAKE_PIN_BIAS_CTRL_ADDR:  read_data = bias_r;
      default:                   read_data = 8'h00;
    endcase
  end

  // Shift engine; slave samples on rising and drives on falling serial clock
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bit_cnt_r  <= 5'h00;
      rx_r       <= 16'h0000;
      tx_r       <= 8'h00;
      spi_sdo    <= 1'b0;
      spi_sdo_en <= 1'b0;
    end else if (clk_en) begin
      if (frame_start) begin
        bit_cnt_r  <= 5'h00;
        tx_r       <= 8'h00;
        spi_sdo    <= 1'b0;
        spi_sdo_en <= 1'b1;
      end else if (csn_sync_r[1]) begin
        spi_sdo_en <= 1'b0;
      end else begin
        if (sclk_rise && bit_cnt_r != 5'h1F) begin
          rx_r      <= {sdi_sync_r[1], rx_r[15:1]};
          bit_cnt_r <= bit_cnt_r + 5'h01;
        end
        if (sclk_rise && bit_cnt_r == `ADDR_RW_BITS - 5'h01) begin
          // This edge carries the write flag; the address is already shifted in
          case (rx_r[15:9])
            `PEAK_THRESHOLD_CTRL_ADDR: tx_r <= peak_r;
            `INTERNAL_WAKE_CTRL_ADDR:  tx_r <= internal_r;
            `EXTERNAL_WAKE_CTRL_ADDR:  tx_r <= external_r;
            `WAKE_PIN_BIAS_CTRL_ADDR:  tx_r <= bias_r;
            default:                   tx_r <= 8'h00;
          endcase
        end else if (sclk_fall && bit_cnt_r >= `ADDR_RW_BITS) begin
          spi_sdo <= tx_r[0];
          tx_r    <= {1'b0, tx_r[7:1]};
        end
      end
    end
  end

  // Fault only for writes to no register of this bank
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      write_fault <= 1'b0;
    end else if (clk_en) begin
      write_fault <= 1'b0;
      if (wr_commit && read_data == 8'h00 &&
          wr_addr != `PEAK_THRESHOLD_CTRL_ADDR && wr_addr != `INTERNAL_WAKE_CTRL_ADDR &&
          wr_addr != `EXTERNAL_WAKE_CTRL_ADDR && wr_addr != `WAKE_PIN_BIAS_CTRL_ADDR) begin
        write_fault <= 1'b1;
      end
      // A refused peak write in Stop is silent: no fault here, no status event
    end
  end

  // One-shot mode entries
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mode_prev_r <= wake_source_pkg::MODE_INIT;
    end else if (clk_en) begin
      mode_prev_r <= chip_mode;
    end
  end

  always_ff @(posedge clock) begin
    if (por) begin
      peak_r <= `PEAK_RESET_VALUE;
    end else if (clk_en) begin
      if (enter_restart) begin
        peak_r <= peak_r & `PEAK_RESTART_KEEP;
      end else if (wr_commit && wr_addr == `PEAK_THRESHOLD_CTRL_ADDR && wr_peak_ok) begin
        peak_r <= wr_data & `PEAK_WRITE_MASK;
      end
    end
  end

  // Timer wakes and watchdog bit
  always_ff @(posedge clock) begin
    if (por) begin
      internal_r <= `INTERNAL_RESET_VALUE;
    end else if (clk_en) begin
      if (wr_commit && wr_addr == `INTERNAL_WAKE_CTRL_ADDR) begin
        internal_r <= wr_data & `INTERNAL_WRITE_MASK;
      end
      // Device update of the watchdog bit wins over a host write in the same cycle
      if (wd_off_hi_hw_set) begin
        internal_r[`STOP_WATCHDOG_OFF_HI_BIT] <= 1'b1;
      end else if (wd_off_hi_hw_clr) begin
        internal_r[`STOP_WATCHDOG_OFF_HI_BIT] <= 1'b0;
      end
    end
  end

  // Fail-safe outranks restart
  always_ff @(posedge clock) begin
    if (por) begin
      external_r <= `EXTERNAL_RESET_VALUE;
    end else if (clk_en) begin
      if (enter_failsafe) begin
        external_r <= (external_r & `EXTERNAL_FAILSAFE_KEEP) | `EXTERNAL_FAILSAFE_SET;
      end else if (enter_restart) begin
        external_r <= external_r & `EXTERNAL_RESTART_KEEP;
      end else if (wr_commit && wr_addr == `EXTERNAL_WAKE_CTRL_ADDR) begin
        external_r <= wr_data & `EXTERNAL_WRITE_MASK;
      end
    end
  end

  // Pull fields
  always_ff @(posedge clock) begin
    if (por) begin
      bias_r <= `BIAS_RESET_VALUE;
    end else if (clk_en) begin
      if (wr_commit && wr_addr == `WAKE_PIN_BIAS_CTRL_ADDR) begin
        bias_r <= wr_data & `BIAS_WRITE_MASK;
      end
    end
  end

  // Fail-safe pattern for the bus control register, held outside this bank
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bus_failsafe_load  <= 1'b0;
      bus_failsafe_keep  <= `BUS_FAILSAFE_KEEP;
      bus_failsafe_value <= `BUS_FAILSAFE_SET;
    end else if (clk_en) begin
      bus_failsafe_load  <= enter_failsafe;
      bus_failsafe_keep  <= `BUS_FAILSAFE_KEEP;
      bus_failsafe_value <= `BUS_FAILSAFE_SET;
    end
  end

  // Decoded controls; registered so every output leaves a flip-flop
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      supply_peak_threshold_select <= 1'b0;
      second_timer_wake_enable     <= 1'b0;
      first_timer_wake_enable      <= 1'b0;
      stop_watchdog_off_hi         <= 1'b0;
      stop_watchdog_disable        <= 1'b0;
      int_all_status               <= 1'b0;
      wake_pin_measure_select      <= 1'b0;
      measure_active               <= 1'b0;
      level_status_valid           <= 1'b1;
      wake_input_one_enable        <= 1'b0;
      wake_input_two_enable        <= 1'b0;
      wake_input_three_enable      <= 1'b0;
      can_wake_capable             <= 1'b0;
    end else if (clk_en) begin
      supply_peak_threshold_select <= peak_r[`PEAK_THRESHOLD_BIT];
      second_timer_wake_enable     <= internal_r[`SECOND_TIMER_WAKE_BIT];
      first_timer_wake_enable      <= internal_r[`FIRST_TIMER_WAKE_BIT];
      stop_watchdog_off_hi         <= internal_r[`STOP_WATCHDOG_OFF_HI_BIT];
      // Both companion bits must agree so one flipped bit cannot drop supervision
      stop_watchdog_disable        <= internal_r[`STOP_WATCHDOG_OFF_HI_BIT] &
                                      stop_watchdog_off_lo;

      int_all_status               <= external_r[`INT_SCOPE_ALL_BIT];
      wake_pin_measure_select      <= external_r[`MEASURE_SELECT_BIT];
      measure_active               <= external_r[`MEASURE_SELECT_BIT] &&
                                      (chip_mode == wake_source_pkg::MODE_NORMAL);
      level_status_valid           <= ~external_r[`MEASURE_SELECT_BIT];
      wake_input_one_enable        <= external_r[`WAKE_ONE_ENABLE_BIT] &
                                      ~external_r[`MEASURE_SELECT_BIT];
      wake_input_two_enable        <= external_r[`WAKE_TWO_ENABLE_BIT] &
                                      ~external_r[`MEASURE_SELECT_BIT];
      wake_input_three_enable      <= external_r[`WAKE_THREE_ENABLE_BIT];
      can_wake_capable             <= (can_mode_field == `CAN_WAKE_PLAIN) ||
                                      (can_mode_field == `CAN_WAKE_SELECTIVE);
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wake_input_one_pull   <= 2'h0;
      wake_input_two_pull   <= 2'h0;
      wake_input_three_pull <= 2'h0;
      pull_up_enable        <= 3'h0;
      pull_down_enable      <= 3'h0;
      pull_auto_enable      <= 3'h0;
    end else if (clk_en) begin
      wake_input_one_pull   <= bias_r[1:0];
      wake_input_two_pull   <= bias_r[3:2];
      wake_input_three_pull <= bias_r[5:4];

      for (int i = 0; i < 3; i++) begin
        pull_up_enable[i]   <= bias_r[2*i +: 2] == wake_source_pkg::PULL_UP;
        pull_down_enable[i] <= bias_r[2*i +: 2] == wake_source_pkg::PULL_DOWN;
        pull_auto_enable[i] <= bias_r[2*i +: 2] == wake_source_pkg::PULL_AUTO;
      end
    end
  end

endmodule

`default_nettype wire

// [verilog/wake_source_map.svh]
// Offsets, field positions, reset values and masks of the wake source control bank.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef WAKE_SOURCE_MAP_SVH
`define WAKE_SOURCE_MAP_SVH

`define PEAK_THRESHOLD_CTRL_ADDR  7'h05
`define INTERNAL_WAKE_CTRL_ADDR   7'h06
`define EXTERNAL_WAKE_CTRL_ADDR   7'h07
`define WAKE_PIN_BIAS_CTRL_ADDR   7'h08

`define PEAK_THRESHOLD_BIT        5
`define SECOND_TIMER_WAKE_BIT     7
`define FIRST_TIMER_WAKE_BIT      6
`define STOP_WATCHDOG_OFF_HI_BIT  2
`define INT_SCOPE_ALL_BIT         7
`define MEASURE_SELECT_BIT        5
`define WAKE_THREE_ENABLE_BIT     2
`define WAKE_TWO_ENABLE_BIT       1
`define WAKE_ONE_ENABLE_BIT       0

`define PEAK_WRITE_MASK           8'h20
`define INTERNAL_WRITE_MASK       8'hC4
`define EXTERNAL_WRITE_MASK       8'hA7
`define BIAS_WRITE_MASK           8'h3F

`define PEAK_RESET_VALUE          8'h00
`define INTERNAL_RESET_VALUE      8'h00
`define EXTERNAL_RESET_VALUE      8'h07
`define BIAS_RESET_VALUE          8'h00

`define PEAK_RESTART_KEEP         8'h20
`define EXTERNAL_RESTART_KEEP     8'hA7
`define EXTERNAL_FAILSAFE_KEEP    8'hA0
`define EXTERNAL_FAILSAFE_SET     8'h07
`define BUS_FAILSAFE_KEEP         8'hE0
`define BUS_FAILSAFE_SET          8'h09

`define CAN_WAKE_PLAIN            3'h1
`define CAN_WAKE_SELECTIVE        3'h5

`define FRAME_BITS                5'h10
`define ADDR_RW_BITS              5'h08

`endif

// [verilog/wake_source_pkg.sv]
// Types shared by the wake source control bank.
// Assumes the device state machine supplies its mode in this encoding.
package wake_source_pkg;
  typedef enum logic [2:0] {
    MODE_INIT      = 3'b000,
    MODE_NORMAL    = 3'b001,
    MODE_STOP      = 3'b010,
    MODE_SLEEP     = 3'b011,
    MODE_RESTART   = 3'b100,
    MODE_FAIL_SAFE = 3'b101
  } chip_mode_t;

  typedef enum logic [1:0] {
    PULL_NONE = 2'b00,
    PULL_DOWN = 2'b01,
    PULL_UP   = 2'b10,
    PULL_AUTO = 2'b11
  } pull_mode_t;
endpackage

// [sim/wake_host_model.sv]
// Host side of the serial register port: 16-bit frames, address first, least significant bit first.
// Assumes the bank samples these pins on the same clock through two-stage synchronisers.
`timescale 1ns/1ps
`default_nettype none
module wake_host_model (
  input  wire logic clock,
  output logic      csn_n,
  output logic      sclk,
  output logic      sdi,
  input  wire logic sdo
);
  initial begin
    csn_n = 1'b1;
    sclk  = 1'b0;
    sdi   = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Five-clock phases: slower than needed, but safe through the synchronisers
  task automatic xfer(input logic [6:0] a, input logic wr, input logic [7:0] d,
                      output logic [7:0] q);
    logic [15:0] w;
    w = {d, wr, a};
    q = 8'h00;
    csn_n = 1'b0;
    for (int i = 0; i < 16; i++) begin
      sdi = w[i];
      tick(5);
      if (i > 7) q[i-8] = sdo;
      sclk = 1'b1;
      tick(5);
      sclk = 1'b0;
    end
    tick(5);
    csn_n = 1'b1;
    sdi = ~sdi;
    tick(6);
  endtask
endmodule
`default_nettype wire

// [sim/wake_source_control_regs_sva.sv]
// Port-level checks for the wake source control bank.
// Assumes clk_en stays high; a frozen enable would stretch every lag below.
`timescale 1ns/1ps
`default_nettype none
module wake_source_control_regs_sva (
  input wire logic                        clock,
  input wire logic                        sys_rst,
  input wire logic                        soft_rst,
  input wire wake_source_pkg::chip_mode_t chip_mode,
  input wire logic                        stop_watchdog_off_lo,
  input wire logic [2:0]                  can_mode_field,
  input wire logic                        supply_peak_threshold_select,
  input wire logic                        stop_watchdog_off_hi,
  input wire logic                        stop_watchdog_disable,
  input wire logic                        wake_pin_measure_select,
  input wire logic                        measure_active,
  input wire logic                        level_status_valid,
  input wire logic                        wake_input_one_enable,
  input wire logic                        wake_input_two_enable,
  input wire logic                        wake_input_three_enable,
  input wire logic [1:0]                  wake_input_one_pull,
  input wire logic [2:0]                  pull_up_enable,
  input wire logic [2:0]                  pull_down_enable,
  input wire logic [2:0]                  pull_auto_enable,
  input wire logic                        can_wake_capable,
  input wire logic                        bus_failsafe_load,
  input wire logic [7:0]                  bus_failsafe_keep,
  input wire logic [7:0]                  bus_failsafe_value
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  AST_MEASURE_MASK: assert property (wake_pin_measure_select |->
    !wake_input_one_enable && !wake_input_two_enable) else $error("wake input on while measuring");
  AST_LEVEL_STATUS: assert property (level_status_valid != wake_pin_measure_select)
    else $error("level status validity wrong");
  AST_MEASURE_MODE: assert property (measure_active |-> wake_pin_measure_select &&
    $past(chip_mode) == wake_source_pkg::MODE_NORMAL) else $error("measurement outside normal");
  AST_PULL_DECODE: assert property (pull_up_enable[0] == (wake_input_one_pull == 2'h2) &&
    pull_down_enable[0] == (wake_input_one_pull == 2'h1) &&
    pull_auto_enable[0] == (wake_input_one_pull == 2'h3)) else $error("pull decode wrong");
  AST_CAN_WAKE: assert property (!$past(sys_rst) |->
    can_wake_capable == ($past(can_mode_field) inside {3'h1, 3'h5})) else $error("bus wake wrong");
  AST_WD_DISABLE: assert property (stop_watchdog_disable |->
    stop_watchdog_off_hi && $past(stop_watchdog_off_lo)) else $error("watchdog disable wrong");
  AST_FS_LOAD: assert property ($rose(chip_mode == wake_source_pkg::MODE_FAIL_SAFE) |->
    ##[1:3] bus_failsafe_load) else $error("no fail-safe load");
  AST_FS_PATTERN: assert property (bus_failsafe_load |-> bus_failsafe_keep == 8'hE0 &&
    bus_failsafe_value == 8'h09 ##1 !bus_failsafe_load) else $error("fail-safe pattern wrong");
  AST_PEAK_STOP_HOLD: assert property (chip_mode == wake_source_pkg::MODE_STOP && !soft_rst |->
    ##2 $stable(supply_peak_threshold_select)) else $error("peak bit changed in stop");
  AST_EXT_RESET: assert property ($fell(sys_rst) |-> ##[0:2] wake_input_three_enable)
    else $error("wake input three not enabled after reset");
endmodule
bind wake_source_control_regs wake_source_control_regs_sva i_sva (.clock, .sys_rst, .soft_rst,
  .chip_mode, .stop_watchdog_off_lo, .can_mode_field, .supply_peak_threshold_select,
  .stop_watchdog_off_hi, .stop_watchdog_disable, .wake_pin_measure_select, .measure_active,
  .level_status_valid, .wake_input_one_enable, .wake_input_two_enable, .wake_input_three_enable,
  .wake_input_one_pull, .pull_up_enable, .pull_down_enable, .pull_auto_enable, .can_wake_capable,
  .bus_failsafe_load, .bus_failsafe_keep, .bus_failsafe_value);
`default_nettype wire

// [sim/tb_wake_source_control_regs.sv]
// Self-checking bench for the wake source control bank, random writes plus corner cases.
// Assumes the host model paces frames slowly enough for the serial synchronisers.
`timescale 1ns/1ps
`default_nettype none
module tb_wake_source_control_regs;
  logic                        clock, sys_rst, clk_en, soft_rst, stop_watchdog_off_lo, spi_sdo_en;
  logic                        wd_off_hi_hw_set, wd_off_hi_hw_clr, spi_csn_n, spi_clk, spi_sdi;
  logic                        spi_sdo, write_fault, supply_peak_threshold_select, int_all_status;
  logic                        second_timer_wake_enable, first_timer_wake_enable, measure_active;
  logic                        stop_watchdog_off_hi, stop_watchdog_disable, wake_pin_measure_select;
  logic                        level_status_valid, wake_input_one_enable, wake_input_two_enable;
  logic                        wake_input_three_enable, can_wake_capable, bus_failsafe_load;
  logic [1:0]                  wake_input_one_pull, wake_input_two_pull, wake_input_three_pull;
  logic [2:0]                  can_mode_field, pull_up_enable, pull_down_enable, pull_auto_enable;
  wake_source_pkg::chip_mode_t chip_mode;
  logic [7:0]                  mdl [4];
  logic [31:0]                 seed = 32'h00005CC2;
  int                          err_total, samples_checked, wf_seen, fs_seen;

  wake_source_control_regs i_wake_source_control_regs (.clock, .sys_rst, .clk_en, .soft_rst,
    .chip_mode, .stop_watchdog_off_lo, .wd_off_hi_hw_set, .wd_off_hi_hw_clr, .can_mode_field,
    .spi_csn_n, .spi_clk, .spi_sdi, .spi_sdo, .spi_sdo_en, .write_fault,
    .supply_peak_threshold_select, .second_timer_wake_enable, .first_timer_wake_enable,
    .stop_watchdog_off_hi, .stop_watchdog_disable, .int_all_status, .wake_pin_measure_select,
    .measure_active, .level_status_valid, .wake_input_one_enable, .wake_input_two_enable,
    .wake_input_three_enable, .wake_input_one_pull, .wake_input_two_pull, .wake_input_three_pull,
    .pull_up_enable, .pull_down_enable, .pull_auto_enable, .can_wake_capable, .bus_failsafe_load,
    .bus_failsafe_keep(), .bus_failsafe_value());
  wake_host_model i_wake_host_model (.clock, .csn_n(spi_csn_n), .sclk(spi_clk), .sdi(spi_sdi),
    .sdo(spi_sdo));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    if (write_fault === 1'b1) wf_seen++;
    if (bus_failsafe_load === 1'b1) fs_seen++;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] wmask(input logic [6:0] a);
    case (a)
      7'h05: return 8'h20;
      7'h06: return 8'hC4;
      7'h07: return 8'hA7;
      7'h08: return 8'h3F;
      default: return 8'h00;
    endcase
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Model update skips the peak bit in stop, where the bank ignores host writes to it
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    i_wake_host_model.xfer(a, 1'b1, d, q);
    if (a > 7'h04 && a < 7'h09 && !(a == 7'h05 && chip_mode == wake_source_pkg::MODE_STOP))
      mdl[a-5] = d & wmask(a);
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] q;
    i_wake_host_model.xfer(a, 1'b0, 8'h00, q);
    check("readback", 16'(exp), 16'(q));
  endtask
  task automatic chk_outs();
    logic [15:0] e;
    logic        m;
    m = mdl[2][5];
    e = {mdl[0][5], mdl[1][7], mdl[1][6], mdl[1][2], mdl[2][7], m, ~m,
         m & (chip_mode == wake_source_pkg::MODE_NORMAL), mdl[2][2], mdl[2][1] & ~m,
         mdl[2][0] & ~m, mdl[1][2] & stop_watchdog_off_lo, 4'h0};
    check("control outputs", e, {supply_peak_threshold_select, second_timer_wake_enable,
      first_timer_wake_enable, stop_watchdog_off_hi, int_all_status, wake_pin_measure_select,
      level_status_valid, measure_active, wake_input_three_enable, wake_input_two_enable,
      wake_input_one_enable, stop_watchdog_disable, 4'h0});
    e = {1'b0, mdl[3][5:0], 9'h000};
    for (int k = 0; k < 3; k++) begin
      e[k] = mdl[3][2*k+:2] == 2'h2;
      e[3+k] = mdl[3][2*k+:2] == 2'h1;
      e[6+k] = mdl[3][2*k+:2] == 2'h3;
    end
    check("pull outputs", e, {spi_sdo_en, wake_input_three_pull, wake_input_two_pull,
      wake_input_one_pull, pull_auto_enable, pull_down_enable, pull_up_enable});
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    logic [6:0] ra;
    int         n;
    {sys_rst, clk_en, soft_rst, stop_watchdog_off_lo} = 4'hC;
    {wd_off_hi_hw_set, wd_off_hi_hw_clr, can_mode_field} = 5'h00;
    chip_mode = wake_source_pkg::MODE_INIT;
    mdl = '{8'h00, 8'h00, 8'h07, 8'h00};
    step(8);
    sys_rst = 1'b0;
    step(3);
    chk_outs();
    for (int a = 5; a < 9; a++) rd_chk(7'(a), mdl[a-5]);
    rd_chk(7'h7F, 8'h00);
    wr(7'h05, 8'hFF);
    rd_chk(7'h05, 8'h20);
    chip_mode = wake_source_pkg::MODE_NORMAL;
    for (int i = 0; i < 16; i++) begin
      ra = 7'h05 + 7'(rnd() & 32'h3);
      wr(ra, 8'(rnd()));
      stop_watchdog_off_lo = rnd() > 32'h7FFFFFFF;
      rd_chk(ra, mdl[ra-5]);
      chk_outs();
    end
    wr(7'h07, 8'h27);
    chk_outs();
    chip_mode = wake_source_pkg::MODE_STOP;
    n = wf_seen;
    wr(7'h05, ~mdl[0]);
    rd_chk(7'h05, mdl[0]);
    chk_outs();
    check("write faults", 16'(n), 16'(wf_seen));
    clk_en = 1'b0;
    wr(7'h3C, 8'h5A);
    clk_en = 1'b1;
    wr(7'h3C, 8'h5A);
    check("write faults", 16'(n + 1), 16'(wf_seen));
    chip_mode = wake_source_pkg::MODE_NORMAL;
    wr(7'h05, 8'h20);
    wr(7'h07, 8'hFF);
    chip_mode = wake_source_pkg::MODE_RESTART;
    step(3);
    chip_mode = wake_source_pkg::MODE_NORMAL;
    mdl[0] = mdl[0] & 8'h20;
    mdl[2] = mdl[2] & 8'hA7;
    for (int a = 5; a < 9; a++) rd_chk(7'(a), mdl[a-5]);
    wr(7'h07, 8'hA0);
    n = fs_seen;
    chip_mode = wake_source_pkg::MODE_FAIL_SAFE;
    step(4);
    chip_mode = wake_source_pkg::MODE_NORMAL;
    mdl[2] = (mdl[2] & 8'hA0) | 8'h07;
    rd_chk(7'h07, mdl[2]);
    check("fail-safe loads", 16'(n + 1), 16'(fs_seen));
    stop_watchdog_off_lo = 1'b1;
    for (int i = 0; i < 2; i++) begin
      {wd_off_hi_hw_set, wd_off_hi_hw_clr} = (i == 0) ? 2'h2 : 2'h1;
      step(1);
      {wd_off_hi_hw_set, wd_off_hi_hw_clr} = 2'h0;
      mdl[1][2] = (i == 0);
      step(3);
      rd_chk(7'h06, mdl[1]);
      chk_outs();
    end
    for (int c = 0; c < 8; c++) begin
      can_mode_field = 3'(c);
      step(3);
      check("bus wake", 16'(c == 1 || c == 5), 16'(can_wake_capable));
    end
    soft_rst = 1'b1;
    step(1);
    soft_rst = 1'b0;
    mdl = '{8'h00, 8'h00, 8'h07, 8'h00};
    step(3);
    chk_outs();
    rd_chk(7'h07, 8'h07);
    sys_rst = 1'b1;
    step(2);
    sys_rst = 1'b0;
    step(3);
    chk_outs();
    results();
  end
  // Run needs about 9500 clocks; this bound leaves a wide margin
  initial begin
    repeat (40000) @(posedge clock);
    err_total++;
    results();
  end
endmodule
`default_nettype wire
